// *** core/crfda_pkg.sv ***
/*
 package for the working register file and data-space address unit:
 region limits, addressing modes, request and answer structs.
 assumes a single system clock shared by decoder, alu and sram.
*/
package crfda_pkg;
    localparam int NUM_REGS      = 32;
    localparam int IO_REGS       = 64;
    localparam logic [15:0] IO_BASE   = 16'h0020;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam int SRAM_SIZE_SMALL = 256;
    localparam int SRAM_SIZE_LARGE = 512;
    localparam logic [4:0] IMM_REG_BASE = 5'h10;
    localparam logic [4:0] PTR_A_LO = 5'h1a;
    localparam logic [4:0] PTR_B_LO = 5'h1c;
    localparam logic [4:0] PTR_C_LO = 5'h1e;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [2:0] {
        CRF_MODE_NONE   = 3'h0,
        CRF_MODE_DIRECT = 3'h1,
        CRF_MODE_IO     = 3'h2,
        CRF_MODE_IND    = 3'h3,
        CRF_MODE_DISP   = 3'h4,
        CRF_MODE_PREDEC = 3'h5,
        CRF_MODE_POSTINC= 3'h6,
        CRF_MODE_LOOKUP = 3'h7
    } crf_mode_t;

    typedef enum logic [1:0] {
        CRF_PTR_A = 2'h0,
        CRF_PTR_B = 2'h1,
        CRF_PTR_C = 2'h2
    } crf_ptr_t;

    typedef enum logic [1:0] {
        CRF_RGN_REG  = 2'h0,
        CRF_RGN_IO   = 2'h1,
        CRF_RGN_SRAM = 2'h2,
        CRF_RGN_NONE = 2'h3
    } crf_rgn_t;

    // alu-side operation for one cycle
    typedef struct packed {
        logic       wr_en;
        logic       imm_op;
        logic [4:0] dest_reg_field;
        logic [4:0] src_reg_field;
        logic [7:0] result;
    } crf_alu_req_t;

    // memory-side addressing request
    typedef struct packed {
        logic       valid;
        crf_mode_t  mode;
        crf_ptr_t   ptr;
        logic [5:0] disp;
        logic [5:0] io_addr;
        logic [15:0] direct_addr;
        logic       store;
        logic [4:0] data_reg;
    } crf_mem_req_t;

    typedef struct packed {
        logic       valid;
        crf_rgn_t   region;
        logic [15:0] addr;
        logic       store;
        logic [7:0] wdata;
    } crf_mem_cmd_t;
endpackage : crfda_pkg

// *** core/crfda_top.sv ***
/*
 working register file (32 x 8) with three 16-bit index pointers and
 data-space address generation for all data addressing modes.
 assumes decoder, alu and data memory on I_CLK_SYS; memory answers
 loads by I_LOAD_VALID with data that is written to the named register.
*/
// Functional notes
// RQ1: thirty-two 8-bit registers; two reads, alu result written back same cycle.
// RQ2: top six registers double as three 16-bit pointers, still general purpose.
// RQ3: pointers pair even low byte, odd high byte: 27:26, 29:28, 31:30.
// RQ4: registers occupy the lowest 32 data-space addresses.
// RQ5: pointer accesses reach the working registers through that mapping. Code does this for stores only; loads there go out on O_MEM_CMD.
// RQ6: 64 i/o addresses reachable directly and at data addresses 0x20..0x5f.
// RQ7: first 96 addresses registers plus i/o, next 256 or 512 sram.
// RQ8: immediate-operand instructions only write registers 16 to 31.
// RQ9: register and single-register operations may select any register.
// RQ10: operands from src and dest fields, result into dest register.
// RQ11: i/o-direct takes 6-bit i/o address; register field selects data register.
// RQ12: direct access takes full 16-bit address from second instruction word.
// RQ13: displacement adds 6-bit unsigned offset to pointer b or c, unchanged.
// RQ14: displacement covers 63 locations beyond the pointer base.
// RQ15: plain indirect uses the unmodified pointer as address.
// RQ16: pre-decrement lowers pointer by one, writes back, uses lowered value.
// RQ17: post-increment uses original pointer, then writes back pointer plus one.
// RQ18: one pointer also supplies program-memory byte address for constant look-up.
// RQ19: look-up word from pointer c bits 15..1; bit 0 picks high byte.
`timescale 1ns/10ps
`default_nettype none
module crfda_top
    import crfda_pkg::*;
#(
    parameter int SRAM_SIZE = SRAM_SIZE_SMALL
)(
    input  wire logic                   I_CLK_SYS,      // system clock
    input  wire logic                   I_SRST,         // sync reset, high
    input  wire crfda_pkg::crf_alu_req_t I_ALU,         // alu operation
    input  wire crfda_pkg::crf_mem_req_t I_MEM,         // memory access request
    input  wire logic                   I_LOAD_VALID,   // load data returns
    input  wire logic [4:0]             I_LOAD_REG,     // load target register
    input  wire logic [7:0]             I_LOAD_DATA,    // load data
    input  wire logic [4:0]             I_RD_A_SEL,     // read port a select
    input  wire logic [4:0]             I_RD_B_SEL,     // read port b select
    output logic [7:0]                  O_RD_A,         // registered port a data
    output logic [7:0]                  O_RD_B,         // registered port b data
    output crfda_pkg::crf_mem_cmd_t     O_MEM_CMD,      // decoded data access
    output logic [5:0]                  O_IO_ADDR,      // i/o register index
    output logic                        O_LOOKUP_VALID, // look-up address valid
    output logic [14:0]                 O_LOOKUP_WORD,  // program word address
    output logic                        O_LOOKUP_HIGH,  // high byte select
    output logic                        O_IMM_REJECT    // illegal imm destination
);
    import crfda_pkg::*;

    logic [7:0] regs_r   [NUM_REGS];
    logic [7:0] regs_nxt [NUM_REGS];

    crf_mem_cmd_t cmd_r;
    crf_mem_cmd_t cmd_nxt;
    logic [5:0]   io_r;
    logic [5:0]   io_nxt;
    logic         lk_v_r;
    logic         lk_v_nxt;
    logic [14:0]  lk_w_r;
    logic [14:0]  lk_w_nxt;
    logic         lk_h_r;
    logic         lk_h_nxt;
    logic         rej_r;
    logic         rej_nxt;
    logic [7:0]   rda_r;
    logic [7:0]   rda_nxt;
    logic [7:0]   rdb_r;
    logic [7:0]   rdb_nxt;

    // region of a data-space address
    function automatic crf_rgn_t region_of(input logic [15:0] a);
        if (a < IO_BASE)
            region_of = CRF_RGN_REG;                                // RQ4
        else if (a < SRAM_BASE)
            region_of = CRF_RGN_IO;                                 // RQ6
        else if (a < SRAM_BASE + 16'(SRAM_SIZE))
            region_of = CRF_RGN_SRAM;                               // RQ7
        else
            region_of = CRF_RGN_NONE;
    endfunction : region_of

    // low register number of a pointer pair
    function automatic logic [4:0] ptr_lo(input crf_ptr_t p);
        unique case (p)
            CRF_PTR_A: ptr_lo = PTR_A_LO;                           // RQ3
            CRF_PTR_B: ptr_lo = PTR_B_LO;                           // RQ3
            default:   ptr_lo = PTR_C_LO;                           // RQ3
        endcase
    endfunction : ptr_lo

    logic [4:0]  plo;
    logic [4:0]  phi;
    logic [15:0] pval;
    logic [15:0] paddr;
    logic [15:0] pnew;
    logic        pwb;
    logic [7:0]  store_data;

    always_comb
    begin
        plo = ptr_lo(I_MEM.ptr);
        phi = plo | 5'h01;
        pval = {regs_r[phi], regs_r[plo]};                          // RQ2
        paddr = pval;                                               // RQ15
        pnew = pval;
        pwb = 1'b0;
        unique case (I_MEM.mode)
            CRF_MODE_DISP:
                // base stays put, offset 0..63
                paddr = pval + {10'h000, I_MEM.disp};               // RQ13 RQ14
            CRF_MODE_PREDEC:
            begin
                pnew = pval - 16'h0001;                             // RQ16
                paddr = pnew;
                pwb = 1'b1;
            end
            CRF_MODE_POSTINC:
            begin
                pnew = pval + 16'h0001;                             // RQ17
                pwb = 1'b1;
            end
            default:
                paddr = pval;
        endcase
        store_data = regs_r[I_MEM.data_reg];
    end

    always_comb
    begin
        cmd_nxt = '0;
        io_nxt = io_r;
        lk_v_nxt = 1'b0;
        lk_w_nxt = lk_w_r;
        lk_h_nxt = lk_h_r;
        if (I_MEM.valid)
        begin
            unique case (I_MEM.mode)
                CRF_MODE_DIRECT:
                    cmd_nxt.addr = I_MEM.direct_addr;               // RQ12
                CRF_MODE_IO:
                begin
                    cmd_nxt.addr = IO_BASE + {10'h000, I_MEM.io_addr}; // RQ11 RQ6
                    io_nxt = I_MEM.io_addr;                         // RQ11
                end
                CRF_MODE_LOOKUP:
                begin
                    lk_v_nxt = 1'b1;                                // RQ18
                    lk_w_nxt = {regs_r[PTR_C_LO | 5'h01], regs_r[PTR_C_LO][7:1]}; // RQ19
                    lk_h_nxt = regs_r[PTR_C_LO][0];                 // RQ19
                end
                CRF_MODE_NONE:
                    cmd_nxt.addr = '0;
                default:
                    cmd_nxt.addr = paddr;                           // RQ5
            endcase
            if (I_MEM.mode != CRF_MODE_LOOKUP && I_MEM.mode != CRF_MODE_NONE)
            begin
                cmd_nxt.valid = 1'b1;
                cmd_nxt.region = region_of(cmd_nxt.addr);           // RQ7
                cmd_nxt.store = I_MEM.store;
                cmd_nxt.wdata = store_data;
            end
        end
    end

    // register file write ports: alu, load, register-mapped store, pointer
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
            regs_nxt[i] = regs_r[i];
        rej_nxt = 1'b0;
        if (I_ALU.wr_en)
        begin
            if (I_ALU.imm_op && I_ALU.dest_reg_field < IMM_REG_BASE)
                rej_nxt = 1'b1;                                     // RQ8
            else
                regs_nxt[I_ALU.dest_reg_field] = I_ALU.result;      // RQ1 RQ9 RQ10
        end
        if (I_LOAD_VALID)
            regs_nxt[I_LOAD_REG] = I_LOAD_DATA;                     // RQ4
        if (cmd_r.valid && cmd_r.store && cmd_r.region == CRF_RGN_REG)
            regs_nxt[cmd_r.addr[4:0]] = cmd_r.wdata;                // RQ4 RQ5
        if (I_MEM.valid && pwb)
        begin
            regs_nxt[plo] = pnew[7:0];                              // RQ16 RQ17
            regs_nxt[phi] = pnew[15:8];
        end
        rda_nxt = regs_r[I_RD_A_SEL];                               // RQ1 RQ10
        rdb_nxt = regs_r[I_RD_B_SEL];                               // RQ10
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_r[i] <= REG_RESET;
            cmd_r  <= '0;
            io_r   <= '0;
            lk_v_r <= 1'b0;
            lk_w_r <= '0;
            lk_h_r <= 1'b0;
            rej_r  <= 1'b0;
            rda_r  <= '0;
            rdb_r  <= '0;
        end
        else
        begin
            regs_r <= regs_nxt;
            cmd_r  <= cmd_nxt;
            io_r   <= io_nxt;
            lk_v_r <= lk_v_nxt;
            lk_w_r <= lk_w_nxt;
            lk_h_r <= lk_h_nxt;
            rej_r  <= rej_nxt;
            rda_r  <= rda_nxt;
            rdb_r  <= rdb_nxt;
        end
    end

    assign O_RD_A         = rda_r;
    assign O_RD_B         = rdb_r;
    assign O_MEM_CMD      = cmd_r;
    assign O_IO_ADDR      = io_r;
    assign O_LOOKUP_VALID = lk_v_r;
    assign O_LOOKUP_WORD  = lk_w_r;
    assign O_LOOKUP_HIGH  = lk_h_r;
    assign O_IMM_REJECT   = rej_r;
endmodule : crfda_top
`default_nettype wire

// *** tb/crfda_mem_model.sv ***
/*
 data memory model: stores, and answers loads on the falling edge half a cycle after the command.
 assumes the bench names the load target register.
*/
`timescale 1ns/10ps
`default_nettype none
module crfda_mem_model
    import crfda_pkg::*;
(
    input wire logic                   i_clk,      // clock
    input wire crfda_pkg::crf_mem_cmd_t i_cmd,     // decoded access
    input wire logic [4:0]             i_tgt,      // load target
    output logic                       o_ld_valid, // load pulse
    output logic [4:0]                 o_ld_reg,   // load register
    output logic [7:0]                 o_ld_data   // load data
);
    logic [7:0] mem [0:1023];
    initial {o_ld_valid, o_ld_reg, o_ld_data} = '0;
    always @(negedge i_clk)
    begin
        o_ld_valid <= i_cmd.valid && !i_cmd.store && i_cmd.region != CRF_RGN_NONE;
        o_ld_reg   <= i_tgt;
        // idle data toggles so a stale byte never looks valid
        o_ld_data  <= i_cmd.valid ? mem[i_cmd.addr[9:0]] : ~o_ld_data;
        if (i_cmd.valid && i_cmd.store)
            mem[i_cmd.addr[9:0]] <= i_cmd.wdata;
    end
endmodule : crfda_mem_model
`default_nettype wire

// *** tb/crfda_properties.sv ***
/*
 checker for crfda_top: decode, look-up and reject timing at the ports.
 assumes bind into every crfda_top, one clock, sync reset high.
*/
`timescale 1ns/10ps
`default_nettype none
module crfda_props
    import crfda_pkg::*;
#(
    parameter int SRAM_SIZE = SRAM_SIZE_SMALL
)(
    input wire logic                   I_CLK_SYS,      // clock
    input wire logic                   I_SRST,         // reset
    input wire crfda_pkg::crf_alu_req_t I_ALU,         // alu op
    input wire crfda_pkg::crf_mem_req_t I_MEM,         // mem request
    input wire crfda_pkg::crf_mem_cmd_t O_MEM_CMD,     // decoded access
    input wire logic [5:0]             O_IO_ADDR,      // i/o index
    input wire logic                   O_LOOKUP_VALID, // look-up valid
    input wire logic                   O_LOOKUP_HIGH,  // high byte
    input wire logic                   O_IMM_REJECT    // imm refused
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    a_direct_addr: assert property (
        I_MEM.valid && I_MEM.mode == CRF_MODE_DIRECT
        |=> O_MEM_CMD.valid && O_MEM_CMD.addr == $past(I_MEM.direct_addr))
        else $error("direct address wrong");
    a_io_index: assert property (
        I_MEM.valid && I_MEM.mode == CRF_MODE_IO |=> O_IO_ADDR == $past(I_MEM.io_addr))
        else $error("io index wrong");
    a_lookup_pulse: assert property (
        I_MEM.valid && I_MEM.mode == CRF_MODE_LOOKUP |=> O_LOOKUP_VALID)
        else $error("look-up missing");
    a_imm_reject: assert property (
        I_ALU.wr_en && I_ALU.imm_op && I_ALU.dest_reg_field < IMM_REG_BASE |=> O_IMM_REJECT)
        else $error("low imm not refused");
    a_imm_accept: assert property (
        I_ALU.wr_en && I_ALU.imm_op && I_ALU.dest_reg_field >= IMM_REG_BASE |=> !O_IMM_REJECT)
        else $error("high imm refused");
    a_reg_region: assert property (
        O_MEM_CMD.valid && O_MEM_CMD.addr < IO_BASE |-> O_MEM_CMD.region == CRF_RGN_REG)
        else $error("register region wrong");
    a_io_region: assert property (
        O_MEM_CMD.valid && O_MEM_CMD.addr >= IO_BASE && O_MEM_CMD.addr < SRAM_BASE
        |-> O_MEM_CMD.region == CRF_RGN_IO) else $error("io region wrong");
    a_sram_region: assert property (
        O_MEM_CMD.valid && O_MEM_CMD.addr >= SRAM_BASE |-> O_MEM_CMD.region ==
        (O_MEM_CMD.addr < SRAM_BASE + SRAM_SIZE ? CRF_RGN_SRAM : CRF_RGN_NONE))
        else $error("sram region wrong");
    cover property (O_IMM_REJECT);
    cover property (O_MEM_CMD.valid && O_MEM_CMD.region == CRF_RGN_NONE);
    cover property (O_LOOKUP_VALID && O_LOOKUP_HIGH);
endmodule : crfda_props
bind crfda_top crfda_props #(.SRAM_SIZE(SRAM_SIZE)) props_u (.I_CLK_SYS, .I_SRST, .I_ALU,
    .I_MEM, .O_MEM_CMD, .O_IO_ADDR, .O_LOOKUP_VALID, .O_LOOKUP_HIGH, .O_IMM_REJECT);
`default_nettype wire

// *** tb/crfda_tb_top.sv ***
/*
 testbench for crfda_top: register writes, refusals, pointer modes, decode.
 assumes the memory model answers loads.
*/
`timescale 1ns/10ps
`default_nettype none
module crfda_tb_top;
    import crfda_pkg::*;
    logic clk = 0, srst = 1, lv, luv, luh, rej;
    logic [4:0] rsa = 0, rsb = 0, tgt = 0, lr;
    logic [7:0] ld, rda, rdb;
    logic [5:0] ioa;
    logic [14:0] luw;
    logic [15:0] w;
    crf_alu_req_t alu = '0;
    crf_mem_req_t mreq = '0;
    crf_mem_cmd_t cmd;
    int failures = 0, total_checks = 0, cyc = 0;
    always #20 clk = ~clk;
    crfda_top #(.SRAM_SIZE(256)) dut_u (.I_CLK_SYS(clk), .I_SRST(srst), .I_ALU(alu),
        .I_MEM(mreq), .I_LOAD_VALID(lv), .I_LOAD_REG(lr), .I_LOAD_DATA(ld), .I_RD_A_SEL(rsa),
        .I_RD_B_SEL(rsb), .O_RD_A(rda), .O_RD_B(rdb), .O_MEM_CMD(cmd), .O_IO_ADDR(ioa),
        .O_LOOKUP_VALID(luv), .O_LOOKUP_WORD(luw), .O_LOOKUP_HIGH(luh), .O_IMM_REJECT(rej));
    crfda_mem_model mdl_u (.i_clk(clk), .i_cmd(cmd), .i_tgt(tgt), .o_ld_valid(lv),
        .o_ld_reg(lr), .o_ld_data(ld));
    task print_verdict;
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            failures++;
            print_verdict();
        end
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task t; @(negedge clk); endtask : t
    task rg(input crf_rgn_t e); chk({14'h0, cmd.region}, {14'h0, e}); endtask : rg
    task wr(input logic [4:0] r, input logic [7:0] v, input logic im);
        alu <= '{1'b1, im, r, 5'h00, v};
        t();
        alu <= '0;
    endtask : wr
    task rd2(input logic [4:0] r); // {odd, even} pair
        rsa <= r;
        rsb <= 5'(r + 1);
        t();
        w = {rdb, rda};
    endtask : rd2
    task m(input crf_mode_t md, input crf_ptr_t p, input logic [5:0] d,
           input logic [15:0] a, input logic st, input logic [4:0] r);
        mreq <= '{1'b1, md, p, d, d, a, st, r};
        t();
        mreq <= '0;
    endtask : m
    task setp(input logic [4:0] lo, input logic [15:0] v);
        wr(lo, v[7:0], 1'b0);
        wr(5'(lo + 1), v[15:8], 1'b0);
    endtask : setp
    task sc_alu;
        rd2(5'h00); chk(w, {REG_RESET, REG_RESET});
        wr(5'h05, 8'ha5, 1'b0);
        wr(5'h10, 8'h3c, 1'b1); chk({15'h0, rej}, 16'h0);
        wr(5'h03, 8'h77, 1'b1); chk({15'h0, rej}, 16'h1);
        rd2(5'h02); chk(w, 16'h0000);
        rd2(5'h04); chk(w, 16'ha500);
        rd2(5'h10); chk(w, 16'h003c);
    endtask : sc_alu
    task sc_ptr;
        setp(PTR_A_LO, 16'h0010);
        m(CRF_MODE_POSTINC, CRF_PTR_A, 6'h0, 16'h0, 1'b1, 5'h00);
        chk(cmd.addr, 16'h0010); rg(CRF_RGN_REG);
        rd2(PTR_A_LO); chk(w, 16'h0011);
        setp(PTR_B_LO, 16'h0100);
        m(CRF_MODE_PREDEC, CRF_PTR_B, 6'h0, 16'h0, 1'b1, 5'h00);
        chk(cmd.addr, 16'h00ff); rg(CRF_RGN_SRAM);
        rd2(PTR_B_LO); chk(w, 16'h00ff);
        setp(PTR_C_LO, 16'h0121);
        m(CRF_MODE_DISP, CRF_PTR_C, 6'h3f, 16'h0, 1'b1, 5'h00);
        chk(cmd.addr, 16'h0160); rg(CRF_RGN_NONE);
        rd2(PTR_C_LO); chk(w, 16'h0121);
        m(CRF_MODE_IND, CRF_PTR_C, 6'h0, 16'h0, 1'b1, 5'h00);
        chk(cmd.addr, 16'h0121);
        m(CRF_MODE_LOOKUP, CRF_PTR_C, 6'h0, 16'h0, 1'b0, 5'h00);
        chk({luv, luw}, 16'h8090); chk({15'h0, luh}, 16'h1);
    endtask : sc_ptr
    task sc_decode;
        m(CRF_MODE_DIRECT, CRF_PTR_A, 6'h0, 16'h005f, 1'b1, 5'h00); rg(CRF_RGN_IO);
        m(CRF_MODE_DIRECT, CRF_PTR_A, 6'h0, 16'h001f, 1'b1, 5'h00); rg(CRF_RGN_REG);
        m(CRF_MODE_IO, CRF_PTR_A, 6'h2a, 16'h0, 1'b0, 5'h00); chk({10'h0, ioa}, 16'h2a);
        wr(5'h04, 8'h5a, 1'b0);
        m(CRF_MODE_DIRECT, CRF_PTR_A, 6'h0, 16'h0070, 1'b1, 5'h04);
        chk({8'h0, cmd.wdata}, 16'h5a);
        tgt <= 5'h07;
        m(CRF_MODE_DIRECT, CRF_PTR_A, 6'h0, 16'h0070, 1'b0, 5'h07); rg(CRF_RGN_SRAM);
        t();
        rd2(5'h06); chk(w, 16'h5a00);
    endtask : sc_decode
    initial
    begin
        repeat (6) t();
        srst <= 0;
        t();
        sc_alu();
        sc_ptr();
        sc_decode();
        print_verdict();
    end
endmodule : crfda_tb_top
`default_nettype wire
